// ===== src/mcs_pkg.sv
// package: constants, register map and types of the monitor control and status bank
// Operation
// - status register read returns value, then clears
// - read clear also drops interrupt output
// - suppress bit masks interrupt and halts monitoring
// - config bit 6 pulls power switch low
// - reset pulse only with reset output selected
// - bit 4 gives 10 ms low pulse
// - low tree select enables tree result output
// - supply, tree and reset pins excluded
// - eight-bit pointer selects location, resets zero
// - registers load fixed power-on values
// - start bit runs monitoring, zero shuts down
// - clearing start leaves interrupt output asserted
// - enable bit gates the interrupt pin
// - bit 2 picks interrupt polarity and drive
// - bit 5 pulls intrusion low 10 ms
// - bit 7 restores defaults, then self-clears
// - voltage limit crossings set status bits 0-6
// - low chained interrupt input sets bit 7
// - configuration powers up as 08h, suppressed
// - mask bit blocks interrupt, status still records
// - chained input low drives interrupt when enabled
`default_nettype none

package mcs_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLOCK_HZ = 20000000;
  localparam int unsigned RESET_PULSE_MS = 10;
  localparam int unsigned INTRUSION_CLEAR_MS = 10;
  localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_MS * CLOCK_HZ + 999) / 1000;
  localparam int unsigned INTRUSION_CLEAR_CYCLES = (INTRUSION_CLEAR_MS * CLOCK_HZ + 999) / 1000;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_VOLT_STATUS = 8'h01;
  localparam logic [7:0] OFS_MISC_STATUS = 8'h02;
  localparam logic [7:0] OFS_VOLT_MASK = 8'h03;
  localparam logic [7:0] OFS_MISC_MASK = 8'h04;
  localparam logic [7:0] OFS_DIVISOR = 8'h05;
  localparam logic [7:0] OFS_OT_CONFIG = 8'h06;
  localparam logic [7:0] OFS_CONV_RATE = 8'h07;
  localparam logic [7:0] OFS_CHAN_DISABLE = 8'h08;
  localparam logic [7:0] OFS_RAM_FIRST = 8'h20;
  localparam logic [7:0] OFS_MAKER_ID = 8'h3e;
  localparam logic [7:0] OFS_DIE_REV = 8'h3f;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h08;
  localparam logic [7:0] RST_DIVISOR = 8'h14;
  localparam logic [7:0] RST_OT_CONFIG = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [3:0] PIN_IDLE = 4'hb;

  // ==========================================================
  // field positions
  localparam int unsigned CFG_START = 0;
  localparam int unsigned CFG_INT_EN = 1;
  localparam int unsigned CFG_INT_POL = 2;
  localparam int unsigned CFG_SUPPRESS = 3;
  localparam int unsigned CFG_RESET_PULSE = 4;
  localparam int unsigned CFG_INTRUSION_CLR = 5;
  localparam int unsigned CFG_POWER_SWITCH = 6;
  localparam int unsigned CFG_DEFAULTS = 7;
  localparam int unsigned DIV_OT_EN = 6;
  localparam int unsigned DIV_RST_EN = 7;
  localparam int unsigned VOLT_CHAIN = 7;
  localparam int unsigned PIN_CHAIN = 0;
  localparam int unsigned PIN_BOARD_TEMP = 1;
  localparam int unsigned PIN_INTRUSION = 2;
  localparam int unsigned PIN_TREE_SEL = 3;

  // ==========================================================
  // serial link
  localparam logic [6:0] SLAVE_ADDRESS_DEFAULT = 7'h28;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_ADDR_ACK = 3'b010,
    L_WRITE = 3'b011,
    L_WRITE_ACK = 3'b100,
    L_READ = 3'b101,
    L_READ_ACK = 3'b110
  } mcs_link_state_type;

endpackage

`default_nettype wire

// ===== src/mcs_bank.sv
// module: monitor control and status register bank with two-wire serial slave
`timescale 1ns/1ps
`default_nettype none

module mcs_bank #(
  parameter int unsigned RESET_PULSE_CYCLES = mcs_pkg::RESET_PULSE_CYCLES,
  parameter int unsigned INTRUSION_CLEAR_CYCLES = mcs_pkg::INTRUSION_CLEAR_CYCLES,
  parameter logic [6:0] SLAVE_ADDRESS = mcs_pkg::SLAVE_ADDRESS_DEFAULT,
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DIE_REVISION = 8'h03 // arbitrary value
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic busClock,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [6:0] voltageLimitEvent,
  input wire logic hotTempEvent,
  input wire logic [1:0] fanLimitEvent,
  input wire logic overtempLevel,
  input wire logic intChainIn,
  input wire logic boardTempIn,
  input wire logic intrusionIn,
  output logic intrusionOut,
  output logic intrusionOe,
  input wire logic treeTestSelectIn,
  output logic treeTestResultOut,
  output logic treeTestResultOe,
  output logic intOut,
  output logic intOe,
  output logic powerSwitchDriveOut,
  output logic powerSwitchDriveOe,
  output logic resetOrOvertempOut,
  output logic resetOrOvertempOe,
  output logic monitorRun
);
  import mcs_pkg::*;

  localparam int unsigned RCW = $clog2(RESET_PULSE_CYCLES + 1);
  localparam int unsigned ICW = $clog2(INTRUSION_CLEAR_CYCLES + 1);

  // ==========================================================
  // core pin synchronisers
  logic [3:0] pinRaw, pinS1, pinS2, pinS3, pinLevel;
  logic [3:0] pinAgree;
  assign pinRaw = {treeTestSelectIn, intrusionIn, boardTempIn, intChainIn};
  assign pinAgree = ~(pinS2 ^ pinS3);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pinS1 <= PIN_IDLE;
      pinS2 <= PIN_IDLE;
      pinS3 <= PIN_IDLE;
      pinLevel <= PIN_IDLE;
    end else begin
      pinS1 <= pinRaw;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinLevel <= (pinAgree & pinS2) | (~pinAgree & pinLevel);
    end
  end

  // ==========================================================
  // request handshake, core side
  logic reqToggle, reqWrite, reqPointer;
  logic [7:0] reqData;
  logic reqS1, reqS2, reqS3, ackToggle;
  logic reqEvent, pointerWrite, hostWrite, hostRead;
  logic [7:0] registerPointer, readData, readWord;
  logic [7:0] configuration, voltageEventStatus, miscEventStatus;
  logic [7:0] voltageEventMask, miscEventMask, divisorAndOutputSelect;
  logic [7:0] overtempConfigResolution, conversionRate, channelDisable;
  logic [7:0] valueRam [32];

  assign reqEvent = reqS2 ^ reqS3;
  assign pointerWrite = reqEvent & reqWrite & reqPointer;
  assign hostWrite = reqEvent & reqWrite & ~reqPointer;
  assign hostRead = reqEvent & ~reqWrite;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
      ackToggle <= 1'b0;
    end else begin
      reqS1 <= reqToggle;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
      if (reqEvent) begin
        ackToggle <= ~ackToggle;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      registerPointer <= RST_ZERO;
    end else if (pointerWrite) begin
      registerPointer <= reqData;
    end
  end

  // ==========================================================
  // configuration and self-clearing bits
  logic defaultsRestore, configWrite, resetSelected, overtempSelected;
  logic resetPulseDone, intrusionDone;
  logic [RCW-1:0] resetCount;
  logic [ICW-1:0] intrusionCount;
  logic [7:0] next_configuration;

  assign configWrite = hostWrite && registerPointer == OFS_CONFIG;
  assign defaultsRestore = configWrite && reqData[CFG_DEFAULTS];
  assign resetSelected = divisorAndOutputSelect[DIV_RST_EN] & ~divisorAndOutputSelect[DIV_OT_EN];
  assign overtempSelected = divisorAndOutputSelect[DIV_OT_EN]
    & ~divisorAndOutputSelect[DIV_RST_EN];
  assign resetPulseDone = configuration[CFG_RESET_PULSE] && resetSelected
    && resetCount == RCW'(RESET_PULSE_CYCLES - 1);
  assign intrusionDone = configuration[CFG_INTRUSION_CLR]
    && intrusionCount == ICW'(INTRUSION_CLEAR_CYCLES - 1);

  always_comb begin
    next_configuration = configuration;
    if (resetPulseDone || !resetSelected) begin
      next_configuration[CFG_RESET_PULSE] = 1'b0;
    end
    if (intrusionDone) begin
      next_configuration[CFG_INTRUSION_CLR] = 1'b0;
    end
    if (defaultsRestore) begin
      next_configuration = RST_CONFIG;
    end else if (configWrite) begin
      // pulse bits are set by a write and cleared by hardware or by a defaults restore, never by writing zero
      next_configuration = {1'b0, reqData[6:0]};
      next_configuration[CFG_RESET_PULSE] = reqData[CFG_RESET_PULSE]
        | (configuration[CFG_RESET_PULSE] & ~resetPulseDone);
      next_configuration[CFG_INTRUSION_CLR] = reqData[CFG_INTRUSION_CLR]
        | (configuration[CFG_INTRUSION_CLR] & ~intrusionDone);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      configuration <= RST_CONFIG;
    end else begin
      configuration <= next_configuration;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !configuration[CFG_RESET_PULSE] || !resetSelected) begin
      resetCount <= '0;
    end else begin
      resetCount <= resetCount + RCW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !configuration[CFG_INTRUSION_CLR]) begin
      intrusionCount <= '0;
    end else begin
      intrusionCount <= intrusionCount + ICW'(1);
    end
  end

  // ==========================================================
  // plain read/write registers
  always_ff @(posedge clock) begin
    if (!nrst || defaultsRestore) begin
      voltageEventMask <= RST_ZERO;
      miscEventMask <= RST_ZERO;
      divisorAndOutputSelect <= RST_DIVISOR;
      overtempConfigResolution <= RST_OT_CONFIG;
      conversionRate <= RST_ZERO;
      channelDisable <= RST_ZERO;
    end else if (hostWrite) begin
      if (registerPointer == OFS_VOLT_MASK) begin
        voltageEventMask <= reqData;
      end else if (registerPointer == OFS_MISC_MASK) begin
        miscEventMask <= reqData;
      end else if (registerPointer == OFS_DIVISOR) begin
        divisorAndOutputSelect <= reqData;
      end else if (registerPointer == OFS_OT_CONFIG) begin
        overtempConfigResolution <= reqData;
      end else if (registerPointer == OFS_CONV_RATE) begin
        conversionRate <= reqData;
      end else if (registerPointer == OFS_CHAN_DISABLE) begin
        channelDisable <= reqData;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (hostWrite && registerPointer >= OFS_RAM_FIRST && registerPointer < OFS_MAKER_ID) begin
      valueRam[registerPointer[4:0]] <= reqData;
    end
  end

  // ==========================================================
  // event status, sticky with read clear
  logic [7:0] voltageSet, miscSet;
  logic voltClear, miscClear;

  assign voltageSet = monitorRun ? {~pinLevel[PIN_CHAIN], voltageLimitEvent}
    : 8'h00;
  assign miscSet = monitorRun ? {2'b00, overtempLevel, pinLevel[PIN_INTRUSION], fanLimitEvent,
    ~pinLevel[PIN_BOARD_TEMP], hotTempEvent} : 8'h00;
  assign voltClear = (hostRead && registerPointer == OFS_VOLT_STATUS)
    || defaultsRestore;
  assign miscClear = (hostRead && registerPointer == OFS_MISC_STATUS)
    || defaultsRestore;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      voltageEventStatus <= RST_ZERO;
    end else begin
      voltageEventStatus <= (voltClear ? RST_ZERO : voltageEventStatus) | voltageSet;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      miscEventStatus <= RST_ZERO;
    end else begin
      miscEventStatus <= (miscClear ? RST_ZERO : miscEventStatus) | miscSet;
    end
  end

  // ==========================================================
  // read data
  always_comb begin
    if (registerPointer == OFS_CONFIG) begin
      readWord = configuration;
    end else if (registerPointer == OFS_VOLT_STATUS) begin
      readWord = voltageEventStatus;
    end else if (registerPointer == OFS_MISC_STATUS) begin
      readWord = miscEventStatus;
    end else if (registerPointer == OFS_VOLT_MASK) begin
      readWord = voltageEventMask;
    end else if (registerPointer == OFS_MISC_MASK) begin
      readWord = miscEventMask;
    end else if (registerPointer == OFS_DIVISOR) begin
      readWord = divisorAndOutputSelect;
    end else if (registerPointer == OFS_OT_CONFIG) begin
      readWord = overtempConfigResolution;
    end else if (registerPointer == OFS_CONV_RATE) begin
      readWord = conversionRate;
    end else if (registerPointer == OFS_CHAN_DISABLE) begin
      readWord = channelDisable;
    end else if (registerPointer == OFS_MAKER_ID) begin
      readWord = MAKER_ID;
    end else if (registerPointer == OFS_DIE_REV) begin
      readWord = DIE_REVISION;
    end else if (registerPointer >= OFS_RAM_FIRST && registerPointer < OFS_MAKER_ID) begin
      readWord = valueRam[registerPointer[4:0]];
    end else begin
      readWord = RST_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      readData <= RST_ZERO;
    end else if (hostRead) begin
      readData <= readWord;
    end
  end

  // ==========================================================
  // pin outputs
  logic intActive;
  assign intActive = configuration[CFG_INT_EN] && !configuration[CFG_SUPPRESS]
    && ((|(voltageEventStatus & ~voltageEventMask)) || (|(miscEventStatus & ~miscEventMask))
    || (!pinLevel[PIN_CHAIN] && !voltageEventMask[VOLT_CHAIN]));

  always_ff @(posedge clock) begin
    if (!nrst) begin
      intOe <= 1'b0;
      intOut <= 1'b0;
      monitorRun <= 1'b0;
      powerSwitchDriveOe <= 1'b0;
      powerSwitchDriveOut <= 1'b0;
      resetOrOvertempOe <= 1'b0;
      resetOrOvertempOut <= 1'b0;
      intrusionOe <= 1'b0;
      intrusionOut <= 1'b0;
    end else begin
      intOe <= intActive;
      intOut <= configuration[CFG_INT_POL];
      monitorRun <= configuration[CFG_START] & ~configuration[CFG_SUPPRESS];
      powerSwitchDriveOe <= configuration[CFG_POWER_SWITCH];
      powerSwitchDriveOut <= 1'b0;
      resetOrOvertempOe <= (configuration[CFG_RESET_PULSE] & resetSelected)
        | (overtempSelected & overtempLevel);
      resetOrOvertempOut <= 1'b0;
      intrusionOe <= configuration[CFG_INTRUSION_CLR];
      intrusionOut <= 1'b0;
    end
  end

  // ==========================================================
  // board tree test
  always_ff @(posedge clock) begin
    if (!nrst) begin
      treeTestResultOe <= 1'b0;
      treeTestResultOut <= 1'b0;
    end else begin
      treeTestResultOe <= ~pinLevel[PIN_TREE_SEL];
      // chain holds only the monitored input pins, never select or reset pins
      treeTestResultOut <= ^pinLevel[PIN_INTRUSION:PIN_CHAIN];
    end
  end

  // ==========================================================
  // link domain: reset, pin and acknowledge synchronisers
  logic linkRstS1, linkNrst;
  logic [1:0] busS1, busS2, busS3, busLevel, busPrev, busAgree;
  logic ackS1, ackS2, ackS3;
  logic [7:0] readLatch;
  logic sclRise, sclFall, startCond, stopCond;

  assign busAgree = ~(busS2 ^ busS3);
  assign sclRise = busLevel[1] & ~busPrev[1];
  assign sclFall = ~busLevel[1] & busPrev[1];
  assign startCond = busLevel[1] & busPrev[1] & busPrev[0] & ~busLevel[0];
  assign stopCond = busLevel[1] & busPrev[1] & ~busPrev[0] & busLevel[0];

  always_ff @(posedge busClock) begin
    linkRstS1 <= nrst;
    linkNrst <= linkRstS1;
  end

  always_ff @(posedge busClock) begin
    if (!linkNrst) begin
      busS1 <= 2'b11;
      busS2 <= 2'b11;
      busS3 <= 2'b11;
      busLevel <= 2'b11;
      busPrev <= 2'b11;
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
      ackS3 <= 1'b0;
      readLatch <= RST_ZERO;
    end else begin
      busS1 <= {sclIn, sdaIn};
      busS2 <= busS1;
      busS3 <= busS2;
      busLevel <= (busAgree & busS2) | (~busAgree & busLevel);
      busPrev <= busLevel;
      ackS1 <= ackToggle;
      ackS2 <= ackS1;
      ackS3 <= ackS2;
      if (ackS2 ^ ackS3) begin
        readLatch <= readData;
      end
    end
  end

  // ==========================================================
  // link domain: serial slave
  mcs_link_state_type linkState;
  logic [7:0] shiftReg;
  logic [3:0] bitCount;
  logic readMode, firstByte, masterAck;

  always_ff @(posedge busClock) begin
    if (!linkNrst) begin
      linkState <= L_IDLE;
      shiftReg <= RST_ZERO;
      bitCount <= 4'h0;
      readMode <= 1'b0;
      firstByte <= 1'b0;
      masterAck <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      reqToggle <= 1'b0;
      reqWrite <= 1'b0;
      reqPointer <= 1'b0;
      reqData <= RST_ZERO;
    end else if (stopCond) begin
      linkState <= L_IDLE;
      sdaOe <= 1'b0;
    end else if (startCond) begin
      linkState <= L_ADDR;
      bitCount <= 4'h0;
      sdaOe <= 1'b0;
    end else begin
      case (linkState)
        L_ADDR: begin
          if (sclRise) begin
            shiftReg <= {shiftReg[6:0], busLevel[0]};
            bitCount <= bitCount + 4'h1;
          end else if (sclFall && bitCount == BITS_PER_BYTE) begin
            if (shiftReg[7:1] == SLAVE_ADDRESS) begin
              sdaOe <= 1'b1;
              readMode <= shiftReg[0];
              linkState <= L_ADDR_ACK;
              if (shiftReg[0]) begin
                reqToggle <= ~reqToggle;
                reqWrite <= 1'b0;
              end
            end else begin
              linkState <= L_IDLE;
            end
          end
        end
        L_ADDR_ACK: begin
          if (sclFall) begin
            bitCount <= 4'h0;
            firstByte <= 1'b1;
            if (readMode) begin
              shiftReg <= readLatch;
              sdaOe <= ~readLatch[7];
              linkState <= L_READ;
            end else begin
              sdaOe <= 1'b0;
              linkState <= L_WRITE;
            end
          end
        end
        L_WRITE: begin
          if (sclRise) begin
            shiftReg <= {shiftReg[6:0], busLevel[0]};
            bitCount <= bitCount + 4'h1;
          end else if (sclFall && bitCount == BITS_PER_BYTE) begin
            reqToggle <= ~reqToggle;
            reqWrite <= 1'b1;
            reqPointer <= firstByte;
            reqData <= shiftReg;
            firstByte <= 1'b0;
            sdaOe <= 1'b1;
            linkState <= L_WRITE_ACK;
          end
        end
        L_WRITE_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
            bitCount <= 4'h0;
            linkState <= L_WRITE;
          end
        end
        L_READ: begin
          if (sclRise) begin
            bitCount <= bitCount + 4'h1;
          end else if (sclFall) begin
            if (bitCount == BITS_PER_BYTE) begin
              sdaOe <= 1'b0;
              linkState <= L_READ_ACK;
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              sdaOe <= ~shiftReg[6];
            end
          end
        end
        L_READ_ACK: begin
          if (sclRise) begin
            masterAck <= ~busLevel[0];
            if (!busLevel[0]) begin
              reqToggle <= ~reqToggle;
              reqWrite <= 1'b0;
            end
          end else if (sclFall) begin
            if (masterAck) begin
              shiftReg <= readLatch;
              sdaOe <= ~readLatch[7];
              bitCount <= 4'h0;
              linkState <= L_READ;
            end else begin
              linkState <= L_IDLE;
            end
          end
        end
        default: begin
          linkState <= L_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== sim/mcs_bank_props.sv
// port assertions of the monitor bank
`timescale 1ns/1ps
`default_nettype none
module mcs_bank_props #(
  parameter int unsigned RESET_PULSE_CYCLES = 20,
  parameter int unsigned INTRUSION_CLEAR_CYCLES = 20
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sdaOut,
  input wire logic overtempLevel,
  input wire logic intChainIn,
  input wire logic boardTempIn,
  input wire logic intrusionIn,
  input wire logic intrusionOut,
  input wire logic intrusionOe,
  input wire logic treeTestSelectIn,
  input wire logic treeTestResultOut,
  input wire logic treeTestResultOe,
  input wire logic intOe,
  input wire logic powerSwitchDriveOut,
  input wire logic resetOrOvertempOut,
  input wire logic resetOrOvertempOe,
  input wire logic monitorRun
);
  int rstCnt;
  int clrCnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock) begin
    rstCnt <= (nrst && resetOrOvertempOe) ? rstCnt + 1 : 0;
  end
  always_ff @(posedge clock) begin
    clrCnt <= (nrst && intrusionOe) ? clrCnt + 1 : 0;
  end
  a_reset_quiet: assert property ($rose(nrst) |-> (!monitorRun && !intOe)[*8])
    else $error("output active after reset");
  a_drain_low: assert property (!sdaOut && !intrusionOut &&
    !powerSwitchDriveOut && !resetOrOvertempOut)
    else $error("open drain pin driven high");
  a_pulse_width: assert property ($fell(resetOrOvertempOe) && !overtempLevel |->
    rstCnt == RESET_PULSE_CYCLES)
    else $error("reset pulse width wrong");
  a_clear_width: assert property ($fell(intrusionOe) |->
    clrCnt == INTRUSION_CLEAR_CYCLES)
    else $error("intrusion clear width wrong");
  a_tree_enter: assert property ($fell(treeTestSelectIn) |-> ##[1:8] treeTestResultOe)
    else $error("tree output not enabled");
  a_tree_leave: assert property (treeTestSelectIn[*8] |-> !treeTestResultOe)
    else $error("tree output enabled outside test");
  a_tree_toggle: assert property (treeTestResultOe && $changed(intrusionIn) |->
    ##[1:8] $changed(treeTestResultOut))
    else $error("tree output missed a toggle");
  a_tree_hold: assert property ((treeTestResultOe && $stable(intChainIn)
    && $stable(boardTempIn) && $stable(intrusionIn))[*8] |-> $stable(treeTestResultOut))
    else $error("tree output moved on quiet pins");
endmodule
bind mcs_bank mcs_bank_props #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES),
  .INTRUSION_CLEAR_CYCLES(INTRUSION_CLEAR_CYCLES)) props (.clock(clock), .nrst(nrst),
  .sdaOut(sdaOut), .overtempLevel(overtempLevel), .intChainIn(intChainIn),
  .boardTempIn(boardTempIn), .intrusionIn(intrusionIn), .intrusionOut(intrusionOut),
  .intrusionOe(intrusionOe), .treeTestSelectIn(treeTestSelectIn),
  .treeTestResultOut(treeTestResultOut), .treeTestResultOe(treeTestResultOe), .intOe(intOe),
  .powerSwitchDriveOut(powerSwitchDriveOut), .resetOrOvertempOut(resetOrOvertempOut),
  .resetOrOvertempOe(resetOrOvertempOe), .monitorRun(monitorRun));
`default_nettype wire

// ===== sim/mcs_host.sv
// two-wire bus master model for the monitor bank
`timescale 1ns/1ps
`default_nettype none
module mcs_host (
  input wire logic busClock,
  input wire logic sdaLine,
  output logic sclDrive,
  output logic sdaLow
);
  import mcs_pkg::*;
  initial begin
    sclDrive = 1'b1;
    sdaLow = 1'b0;
  end
  // quarter bit, 300 ns
  task automatic q();
    repeat (50) @(posedge busClock);
  endtask
  task automatic bitx(input logic b, output logic r);
    sdaLow <= !b;
    q();
    sclDrive <= 1'b1;
    q();
    r = sdaLine;
    q();
    sclDrive <= 1'b0;
    q();
  endtask
  // start or repeated start
  task automatic start();
    sdaLow <= 1'b0;
    q();
    sclDrive <= 1'b1;
    q();
    sdaLow <= 1'b1;
    q();
    sclDrive <= 1'b0;
    q();
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    q();
    sclDrive <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask
  task automatic sendb(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], r);
    end
    bitx(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    start();
    sendb({SLAVE_ADDRESS_DEFAULT, 1'b0});
    sendb(p);
    sendb(v);
    stop();
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic r;
    start();
    sendb({SLAVE_ADDRESS_DEFAULT, 1'b0});
    sendb(p);
    start();
    sendb({SLAVE_ADDRESS_DEFAULT, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, v[i]);
    end
    bitx(1'b1, r);
    stop();
  endtask
endmodule
`default_nettype wire

// ===== sim/mcs_bank_tb.sv
// testbench of the monitor bank
`timescale 1ns/1ps
`default_nettype none
module mcs_bank_tb;
  import mcs_pkg::*;
  logic clock, nrst, busClock, sclIn, hostLow, sdaIn, sdaOe, intChainIn, intrusionIn, btIn;
  logic treeSel, treeOut, treeOe, intOut, intOe, pswOe, rstOe, intrOe, run, saw;
  logic [6:0] volt;
  logic [7:0] d;
  int failCount, nChecks;
  assign sdaIn = !(hostLow || sdaOe);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    busClock = 1'b0;
    #1.3;
    forever #3 busClock = ~busClock;
  end
  mcs_bank #(.RESET_PULSE_CYCLES(20), .INTRUSION_CLEAR_CYCLES(20)) uut (.clock(clock),
    .nrst(nrst), .busClock(busClock), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe),
    .voltageLimitEvent(volt), .hotTempEvent(1'b0), .fanLimitEvent(2'b00), .overtempLevel(1'b0),
    .intChainIn(intChainIn), .boardTempIn(btIn), .intrusionIn(intrusionIn), .intrusionOut(),
    .intrusionOe(intrOe), .treeTestSelectIn(treeSel), .treeTestResultOut(treeOut),
    .treeTestResultOe(treeOe), .intOut(intOut), .intOe(intOe), .powerSwitchDriveOut(),
    .powerSwitchDriveOe(pswOe), .resetOrOvertempOut(), .resetOrOvertempOe(rstOe),
    .monitorRun(run));
  mcs_host host (.busClock(busClock), .sdaLine(sdaIn), .sclDrive(sclIn), .sdaLow(hostLow));
  always @(posedge clock) if (rstOe || intrOe) saw <= 1'b1;
  // ==========================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic ev(input logic [6:0] e);
    @(posedge clock) volt <= e;
    @(posedge clock) volt <= 7'h00;
    cyc(6);
  endtask
  task automatic rdChk(input logic [7:0] p, input logic [7:0] exp);
    host.rd(p, d);
    chk(d, exp);
  endtask
  // ==========================================
  // scenarios
  task automatic checkDefaults();
    logic [7:0] ofs [6] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h02, 8'h10};
    logic [7:0] exp [6] = '{8'h08, 8'h14, 8'h01, 8'h00, 8'h00, 8'h00};
    foreach (ofs[i]) rdChk(ofs[i], exp[i]);
  endtask
  task automatic checkStatus();
    host.wr(OFS_VOLT_MASK, 8'h01);
    host.wr(OFS_CONFIG, 8'h03);
    chk(8'(run), 8'h01);
    ev(7'h01);
    chk(8'(intOe), 8'h00);
    ev(7'h04);
    chk({intOe, intOut}, 8'h02);
    host.wr(OFS_CONFIG, 8'h02);
    chk(8'(intOe), 8'h01);
    host.wr(OFS_CONFIG, 8'h0a);
    chk(8'(intOe), 8'h00);
    host.wr(OFS_CONFIG, 8'h07);
    chk({intOe, intOut}, 8'h03);
    rdChk(OFS_VOLT_STATUS, 8'h05);
    chk(8'(intOe), 8'h00);
    rdChk(OFS_VOLT_STATUS, 8'h00);
    @(posedge clock) intChainIn <= 1'b0;
    cyc(8);
    chk(8'(intOe), 8'h01);
    @(posedge clock) intChainIn <= 1'b1;
    rdChk(OFS_VOLT_STATUS, 8'h80);
  endtask
  task automatic checkOutputs();
    saw <= 1'b0;
    host.wr(OFS_CONFIG, 8'h10);
    rdChk(OFS_CONFIG, 8'h00);
    chk(8'(saw), 8'h00);
    host.wr(OFS_DIVISOR, 8'h94);
    host.wr(OFS_CONFIG, 8'h10);
    rdChk(OFS_CONFIG, 8'h00);
    chk(8'(saw), 8'h01);
    saw <= 1'b0;
    host.wr(OFS_CONFIG, 8'h20);
    rdChk(OFS_CONFIG, 8'h00);
    chk(8'(saw), 8'h01);
    host.wr(OFS_CONFIG, 8'h40);
    chk(8'(pswOe), 8'h01);
    host.wr(OFS_VOLT_MASK, 8'hff);
    host.wr(OFS_CONFIG, 8'h80);
    chk(8'(pswOe), 8'h00);
    rdChk(OFS_VOLT_MASK, 8'h00);
    rdChk(OFS_DIVISOR, 8'h14);
    rdChk(OFS_CONFIG, 8'h08);
  endtask
  task automatic checkTree();
    @(posedge clock) intrusionIn <= 1'b1;
    @(posedge clock) treeSel <= 1'b0;
    cyc(10);
    chk({treeOe, treeOut}, 8'h03);
    @(posedge clock) intChainIn <= 1'b0;
    cyc(10);
    chk(8'(treeOut), 8'h00);
    @(posedge clock) btIn <= 1'b0;
    cyc(10);
    chk(8'(treeOut), 8'h01);
    @(posedge clock) intrusionIn <= 1'b0;
    cyc(10);
    chk(8'(treeOut), 8'h00);
    @(posedge clock) treeSel <= 1'b1;
  endtask
  task automatic reportAndStop();
    if (failCount == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #4_000_000;
    failCount++;
    reportAndStop();
  end
  initial begin
    nrst = 1'b0;
    treeSel = 1'b1;
    intChainIn = 1'b1;
    intrusionIn = 1'b0;
    btIn = 1'b1;
    volt = 7'h00;
    saw = 1'b0;
    failCount = 0;
    nChecks = 0;
    cyc(2);
    nrst <= 1'b1;
    cyc(20);
    checkDefaults();
    checkStatus();
    checkOutputs();
    checkTree();
    reportAndStop();
  end
endmodule
`default_nettype wire
